// File: src/ebi_pkg.sv
package ebi_pkg;

  // --------------------------------------------------------------------
  // clock modes of the processor
  // --------------------------------------------------------------------
  typedef enum logic [2:0] {
    EBI_MODE_13 = 3'h0,
    EBI_MODE_18 = 3'h1,
    EBI_MODE_36 = 3'h2,
    EBI_MODE_49 = 3'h3,
    EBI_MODE_74 = 3'h4
  } ebi_mode_type;

  // --------------------------------------------------------------------
  // bus cycle states, one-hot
  // --------------------------------------------------------------------
  typedef enum logic [2:0] {
    EBI_ST_IDLE   = 3'h1,
    EBI_ST_ACCESS = 3'h2,
    EBI_ST_DONE   = 3'h4
  } ebi_state_type;

  // --------------------------------------------------------------------
  // widths and counts
  // --------------------------------------------------------------------
  localparam int unsigned EBI_NUM_SEL      = 6;
  localparam int unsigned EBI_LOW_SEL      = 4;
  localparam int unsigned EBI_ADDR_W       = 28;
  localparam int unsigned EBI_ADDR_LOW_W   = 15;
  localparam int unsigned EBI_DATA_W       = 32;
  localparam int unsigned EBI_WAIT_W       = 4;
  // mclk cycles of an access before ready and data pins show it
  localparam logic [1:0]  EBI_SETTLE       = 2'h3;

  // --------------------------------------------------------------------
  // fixed expansion clock rate, generated by a phase accumulator
  // --------------------------------------------------------------------
  localparam longint unsigned EBI_MCLK_KHZ  = 64'd50000;
  localparam longint unsigned EBI_FIXED_KHZ = 64'd36864;
  localparam logic [31:0] EBI_NCO_INC =
    32'((EBI_FIXED_KHZ << 32) / EBI_MCLK_KHZ);

  // --------------------------------------------------------------------
  // reset values
  // --------------------------------------------------------------------
  localparam logic [EBI_NUM_SEL-1:0] EBI_SEL_RST  = 6'h3f;
  localparam logic [31:0]            EBI_NCO_RST  = 32'h0;
  localparam logic [1:0]             EBI_SYNC_RST = 2'h0;

endpackage

// File: src/ebi_expansion_bus.sv
`timescale 1ns/1ns
// Notes on behaviour
// - four active-low selects, each low only during accesses to its own region 0..3.
// - two more active-low selects for regions 4 and 5, usable for expansion or a card controller.
// - a slow peripheral holds ready low and the device keeps the cycle open meanwhile.
// - the direction output is low through reads and high through writes.
// - the word output is high for 32-bit transfers and low for byte transfers.
// - the half-word flag is high when the access targets the upper 16 bits.
// - in 18 MHz mode the expansion clock follows the CPU clock.
// - in 36, 49 and 74 MHz modes the expansion clock is a fixed 18.432 MHz, toggling at the 36.864 MHz rate.
// - in 13 MHz mode the expansion clock pin is an input and is never driven.
// - address bits 0..14 and the upper bits go out on the address pins during cycles.
// - the shared output enable is low during expansion reads.
// - the shared write enable is low during expansion writes.
// - in standby all address and data lines are driven low.
module ebi_expansion_bus (
  input  wire logic                      mclk_i,
  input  wire logic                      rstn_i,
  input  wire logic [2:0]                cpu_mode_i,
  input  wire logic                      cpu_tick_i,
  input  wire logic                      standby_i,
  input  wire logic [3:0]                wait_states_i,
  input  wire logic                      req_valid_i,
  output logic                           req_ready_o,
  input  wire logic [2:0]                req_region_i,
  input  wire logic                      req_write_i,
  input  wire logic                      req_word_i,
  input  wire logic                      req_upper_i,
  input  wire logic [27:0]               req_addr_i,
  input  wire logic [31:0]               req_wdata_i,
  output logic                           resp_valid_o,
  output logic [31:0]                    resp_rdata_o,
  output logic [3:0]                     expansion_select_low_group_n_o,
  output logic [1:0]                     expansion_select_high_group_n_o,
  input  wire logic                      expansion_cycle_ready_i,
  output logic                           expansion_cycle_ready_o,
  output logic                           expansion_cycle_ready_oe_n_o,
  output logic                           write_dir_o,
  output logic                           word_access_o,
  output logic                           upper_half_flag_o,
  input  wire logic                      expansion_bus_clock_i,
  output logic                           expansion_bus_clock_o,
  output logic                           expansion_bus_clock_oe_n_o,
  output logic [14:0]                    addr_low_o,
  output logic [12:0]                    addr_high_o,
  input  wire logic [31:0]               data_i,
  output logic [31:0]                    data_o,
  output logic                           data_oe_n_o,
  output logic                           shared_output_enable_n_o,
  output logic                           shared_write_enable_n_o
);

  // --------------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------------
  logic [1:0]  rdy_sync_q;
  logic [1:0]  xclk_sync_q;
  logic        xclk_prev_q;
  logic [31:0] din_s1_q;
  logic [31:0] din_s2_q;

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdy_sync_q  <= ebi_pkg::EBI_SYNC_RST;
      xclk_sync_q <= ebi_pkg::EBI_SYNC_RST;
      xclk_prev_q <= 1'b0;
      din_s1_q    <= 32'h0;
      din_s2_q    <= 32'h0;
    end else begin
      rdy_sync_q  <= {rdy_sync_q[0], expansion_cycle_ready_i};
      xclk_sync_q <= {xclk_sync_q[0], expansion_bus_clock_i};
      xclk_prev_q <= xclk_sync_q[1];
      din_s1_q    <= data_i;
      din_s2_q    <= din_s1_q;
    end
  end

  // --------------------------------------------------------------------
  // expansion clock source selection
  // --------------------------------------------------------------------
  logic [31:0] nco_q;
  logic [32:0] nco_sum;
  logic        xclk_q;
  logic        mode_ext;
  logic        mode_cpu;
  logic        exp_tick;
  logic        exp_rise;

  assign mode_ext = cpu_mode_i == ebi_pkg::EBI_MODE_13;
  assign mode_cpu = cpu_mode_i == ebi_pkg::EBI_MODE_18;
  assign nco_sum  = {1'b0, nco_q} + {1'b0, ebi_pkg::EBI_NCO_INC};
  // toggle source: cpu tick or fixed-rate accumulator carry
  assign exp_tick = mode_cpu ? cpu_tick_i : nco_sum[32];
  // rising edge of the expansion clock, own or external
  assign exp_rise = mode_ext ? (xclk_sync_q[1] & ~xclk_prev_q)
                             : (exp_tick & ~xclk_q);

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      nco_q  <= ebi_pkg::EBI_NCO_RST;
      xclk_q <= 1'b0;
    end else begin
      nco_q <= nco_sum[31:0];
      if (mode_ext) begin
        xclk_q <= 1'b0;
      end else if (exp_tick) begin
        xclk_q <= ~xclk_q;
      end
    end
  end

  assign expansion_bus_clock_o      = xclk_q;
  assign expansion_bus_clock_oe_n_o = mode_ext;
  // ready is never driven by this end
  assign expansion_cycle_ready_o      = 1'b0;
  assign expansion_cycle_ready_oe_n_o = 1'b1;

  // --------------------------------------------------------------------
  // bus cycle sequencer
  // --------------------------------------------------------------------
  ebi_pkg::ebi_state_type state_q;
  ebi_pkg::ebi_state_type state_d;
  logic [3:0]  wait_q;
  logic [2:0]  region_q;
  logic        write_q;
  logic        word_q;
  logic        upper_q;
  logic [27:0] addr_q;
  logic [31:0] wdata_q;
  logic [31:0] rdata_q;
  logic [1:0]  settle_q;
  logic        take;
  logic        finish;
  logic        active;

  assign req_ready_o = (state_q == ebi_pkg::EBI_ST_IDLE) & ~standby_i;
  assign take        = req_valid_i & req_ready_o & (req_region_i < 3'h6);
  assign active      = state_q == ebi_pkg::EBI_ST_ACCESS;
  // complete only at a rising edge with wait spent and ready high
  assign finish = active & exp_rise & (wait_q == 4'h0) & (settle_q == 2'h0)
                & rdy_sync_q[1];

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ebi_pkg::EBI_ST_IDLE: begin
        if (take) begin
          state_d = ebi_pkg::EBI_ST_ACCESS;
        end
      end
      ebi_pkg::EBI_ST_ACCESS: begin
        if (finish) begin
          state_d = ebi_pkg::EBI_ST_DONE;
        end
      end
      ebi_pkg::EBI_ST_DONE: begin
        state_d = ebi_pkg::EBI_ST_IDLE;
      end
      default: begin
        state_d = ebi_pkg::EBI_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_q <= ebi_pkg::EBI_ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // request fields latched once so outputs hold through the cycle
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      region_q <= 3'h0;
      write_q  <= 1'b0;
      word_q   <= 1'b0;
      upper_q  <= 1'b0;
      addr_q   <= 28'h0;
      wdata_q  <= 32'h0;
    end else if (take) begin
      region_q <= req_region_i;
      write_q  <= req_write_i;
      word_q   <= req_word_i;
      upper_q  <= req_upper_i;
      addr_q   <= req_addr_i;
      wdata_q  <= req_wdata_i;
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wait_q <= 4'h0;
    end else if (take) begin
      wait_q <= wait_states_i;
    end else if (active && exp_rise && wait_q != 4'h0) begin
      wait_q <= wait_q - 4'h1;
    end
  end

  // ready and data pins lag two flops; no finish until they show the access
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      settle_q <= 2'h0;
    end else if (take) begin
      settle_q <= ebi_pkg::EBI_SETTLE;
    end else if (active && settle_q != 2'h0) begin
      settle_q <= settle_q - 2'h1;
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_q <= 32'h0;
    end else if (finish && !write_q) begin
      rdata_q <= din_s2_q;
    end
  end

  assign resp_valid_o = state_q == ebi_pkg::EBI_ST_DONE;
  assign resp_rdata_o = rdata_q;

  // --------------------------------------------------------------------
  // pin drive
  // --------------------------------------------------------------------
  logic [5:0] sel_n;

  generate
    for (genvar g = 0; g < 6; g++) begin : g_sel
      // one region decoded, so one select at most
      assign sel_n[g] = ~(active & (region_q == 3'(g)));
    end
  endgenerate

  assign expansion_select_low_group_n_o  = sel_n[3:0];
  assign expansion_select_high_group_n_o = sel_n[5:4];
  assign write_dir_o       = write_q;
  assign word_access_o     = word_q;
  assign upper_half_flag_o = upper_q;
  assign shared_output_enable_n_o = ~(active & ~write_q);
  assign shared_write_enable_n_o  = ~(active & write_q);
  // standby forces address and data low and driven
  assign addr_low_o  = standby_i ? 15'h0 : addr_q[14:0];
  assign addr_high_o = standby_i ? 13'h0 : addr_q[27:15];
  assign data_o      = standby_i ? 32'h0 : wdata_q;
  assign data_oe_n_o = ~(standby_i | (active & write_q));

  // --------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);

  sel_onehot_a: assert property ($onehot0(~sel_n))
    else $error("more than one select low");
  sel_region_a: assert property (active |-> !sel_n[region_q])
    else $error("select of region not low");
  ready_hold_a: assert property (active && !rdy_sync_q[1] |=> active)
    else $error("cycle ended while ready low");
  dir_read_a: assert property (!shared_output_enable_n_o |-> !write_dir_o)
    else $error("read without direction low");
  size_stable_a: assert property (active && $past(active) |->
    $stable({write_dir_o, word_access_o, upper_half_flag_o}))
    else $error("size or direction moved in cycle");
  clk_input_a: assert property (mode_ext |-> expansion_bus_clock_oe_n_o)
    else $error("clock pin driven in external mode");
  standby_low_a: assert property (standby_i |-> addr_low_o == 15'h0
    && addr_high_o == 13'h0 && data_o == 32'h0 && !data_oe_n_o)
    else $error("bus not low in standby");
  we_write_a: assert property (!shared_write_enable_n_o |->
    write_dir_o && !data_oe_n_o)
    else $error("write strobe without write drive");
  settle_min_a: assert property ($rose(active) |-> !finish [*3])
    else $error("cycle ended before pins settled");
  done_pulse_a: assert property (finish |=> resp_valid_o ##1 !resp_valid_o)
    else $error("answer not a single pulse");
  clk_cpu_a: assert property (mode_cpu && cpu_tick_i |=>
    expansion_bus_clock_o != $past(expansion_bus_clock_o))
    else $error("clock did not follow cpu tick");

  read_cov_c:  cover property (take && !req_write_i ##[1:200] resp_valid_o);
  write_cov_c: cover property (take && req_write_i ##[1:200] resp_valid_o);
  stall_cov_c: cover property (active && !rdy_sync_q[1] [*4] ##[1:50] finish);

endmodule // ebi_expansion_bus

// File: sim/ebi_periph_model.sv
`timescale 1ns/1ns
module ebi_periph_model (
  input  wire logic        mclk_i,
  input  wire logic [5:0]  sel_n_i,
  input  wire logic        oe_n_i,
  input  wire logic [14:0] addr_low_i,
  input  wire logic [7:0]  stall_i,
  output logic             rdy_o,
  output logic [31:0]      data_o
);
  logic [7:0]  cnt_q;
  logic [31:0] d_q = 32'h0;
  logic        act;
  assign act = ~&sel_n_i;
  // stretch the cycle for stall_i clocks after select
  always_ff @(posedge mclk_i) begin
    if (!act) cnt_q <= stall_i;
    else if (cnt_q != 8'h0) cnt_q <= cnt_q - 8'h1;
  end
  assign rdy_o = !(act && cnt_q != 8'h0);
  // released bus shows a changing pattern, not the last value
  always_ff @(posedge mclk_i) begin
    if (act && !oe_n_i) d_q <= {17'h0, addr_low_i} ^ 32'h5a5a0000;
    else d_q <= ~d_q;
  end
  assign data_o = d_q;
endmodule // ebi_periph_model

// File: sim/tb.sv
`timescale 1ns/1ns
module tb;
  logic        mclk_i, rstn_i, cpu_tick_i, standby_i, req_valid_i, m_rdy;
  logic        req_write_i, req_word_i, req_upper_i, expansion_bus_clock_i;
  logic [2:0]  cpu_mode_i, req_region_i;
  logic [3:0]  wait_states_i, expansion_select_low_group_n_o;
  logic [27:0] req_addr_i;
  logic [31:0] req_wdata_i, resp_rdata_o, data_i, data_o;
  logic [7:0]  stall;
  logic        req_ready_o, resp_valid_o, expansion_cycle_ready_i;
  logic        expansion_cycle_ready_o, expansion_cycle_ready_oe_n_o;
  logic        write_dir_o, word_access_o, upper_half_flag_o, data_oe_n_o;
  logic        expansion_bus_clock_o, expansion_bus_clock_oe_n_o;
  logic        shared_output_enable_n_o, shared_write_enable_n_o;
  logic [1:0]  expansion_select_high_group_n_o;
  logic [14:0] addr_low_o;
  logic [12:0] addr_high_o;
  int          n_fail, checked, c0, c1;
  ebi_expansion_bus dut_u (.mclk_i, .rstn_i, .cpu_mode_i, .cpu_tick_i,
    .standby_i, .wait_states_i, .req_valid_i, .req_ready_o, .req_region_i,
    .req_write_i, .req_word_i, .req_upper_i, .req_addr_i, .req_wdata_i,
    .resp_valid_o, .resp_rdata_o, .expansion_select_low_group_n_o,
    .expansion_select_high_group_n_o, .expansion_cycle_ready_i,
    .expansion_cycle_ready_o, .expansion_cycle_ready_oe_n_o, .write_dir_o,
    .word_access_o, .upper_half_flag_o, .expansion_bus_clock_i,
    .expansion_bus_clock_o, .expansion_bus_clock_oe_n_o, .addr_low_o,
    .addr_high_o, .data_i, .data_o, .data_oe_n_o, .shared_output_enable_n_o,
    .shared_write_enable_n_o);
  ebi_periph_model part_u (.mclk_i, .oe_n_i(shared_output_enable_n_o),
    .sel_n_i({expansion_select_high_group_n_o, expansion_select_low_group_n_o}),
    .addr_low_i(addr_low_o), .stall_i(stall), .rdy_o(m_rdy), .data_o(data_i));
  assign expansion_cycle_ready_i = m_rdy
    & (expansion_cycle_ready_oe_n_o | expansion_cycle_ready_o);
  initial begin
    mclk_i = 1'b0;
    forever #10 mclk_i = ~mclk_i;
  end
  // cpu ticks in mode 18, external clock in mode 13
  always @(negedge mclk_i) begin
    cpu_tick_i <= (cpu_mode_i == 3'h1) && !cpu_tick_i;
    expansion_bus_clock_i <= (cpu_mode_i == 3'h0) && !expansion_bus_clock_i;
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic xfer(input logic [2:0] rg, input logic wr, wd, up,
                      input logic [27:0] ad, output int cyc);
    logic [5:0] sel;
    cyc = 0;
    @(negedge mclk_i);
    {req_valid_i, req_region_i, req_write_i} = {1'b1, rg, wr};
    {req_word_i, req_upper_i, req_addr_i} = {wd, up, ad};
    req_wdata_i = ~{4'h0, ad};
    @(negedge mclk_i);
    req_valid_i = 1'b0;
    while (resp_valid_o !== 1'b1 && cyc < 400) begin
      sel = {expansion_select_high_group_n_o, expansion_select_low_group_n_o};
      if (~&sel) begin
        chk(sel, 6'(~(6'h1 << rg)));
        chk({write_dir_o, word_access_o, upper_half_flag_o}, {wr, wd, up});
        chk({shared_output_enable_n_o, shared_write_enable_n_o}, {wr, !wr});
        chk({addr_high_o, addr_low_o}, ad);
        if (wr) chk({data_oe_n_o, data_o}, {1'b0, ~{4'h0, ad}});
      end
      cyc++;
      @(negedge mclk_i);
    end
    chk(cyc < 400, 1'b1);
    if (!wr) chk(resp_rdata_o, {17'h0, ad[14:0]} ^ 32'h5a5a0000);
  endtask
  task automatic t_regions;
    for (int r = 0; r < 12; r++) begin
      xfer(3'(r % 6), r >= 6, r[0], r[1], 28'h9abcdef ^ 28'(r * 4099), c0);
    end
  endtask
  task automatic t_stall;
    wait_states_i = 4'h0;
    stall = 8'h14;
    xfer(3'h2, 1'b0, 1'b1, 1'b0, 28'h0001234, c0);
    chk(c0 >= 20, 1'b1);
    stall = 8'h0;
  endtask
  task automatic t_waits;
    xfer(3'h1, 1'b0, 1'b0, 1'b1, 28'h0004321, c0);
    wait_states_i = 4'h8;
    xfer(3'h1, 1'b0, 1'b0, 1'b1, 28'h0004321, c1);
    chk(c1 >= c0 + 14, 1'b1);
    wait_states_i = 4'h3;
  endtask
  task automatic t_standby;
    standby_i = 1'b1;
    repeat (3) @(negedge mclk_i);
    chk({addr_high_o, addr_low_o}, 28'h0);
    chk({req_ready_o, data_oe_n_o, data_o}, 34'h0);
    chk({expansion_cycle_ready_oe_n_o, expansion_cycle_ready_o}, 2'h2);
    standby_i = 1'b0;
    @(negedge mclk_i);
  endtask
  task automatic count_tog(input int n, output int t);
    logic p;
    t = 0;
    p = expansion_bus_clock_o;
    repeat (n) begin
      @(negedge mclk_i);
      if (expansion_bus_clock_o !== p) t++;
      p = expansion_bus_clock_o;
    end
  endtask
  task automatic t_clock;
    for (int m = 2; m < 5; m++) begin
      cpu_mode_i = 3'(m);
      count_tog(1000, c0);
      chk(c0 >= 736 && c0 <= 739, 1'b1);
    end
    cpu_mode_i = 3'h1;
    count_tog(8, c0);
    count_tog(40, c0);
    chk(c0 >= 19 && c0 <= 21, 1'b1);
    chk(expansion_bus_clock_oe_n_o, 1'b0);
    cpu_mode_i = 3'h0;
    repeat (4) @(negedge mclk_i);
    chk(expansion_bus_clock_oe_n_o, 1'b1);
    xfer(3'h5, 1'b0, 1'b1, 1'b0, 28'h7000abc, c0);
    cpu_mode_i = 3'h2;
  endtask
  initial begin
    #200000;
    n_fail++;
    final_report();
  end
  initial begin
    {rstn_i, standby_i, req_valid_i} = 3'h0;
    {req_write_i, req_word_i, req_upper_i, req_region_i} = 6'h0;
    {req_addr_i, req_wdata_i, stall} = 68'h0;
    cpu_mode_i = 3'h2;
    wait_states_i = 4'h3;
    n_fail = 0;
    checked = 0;
    repeat (2) @(negedge mclk_i);
    rstn_i = 1'b1;
    t_regions();
    t_stall();
    t_waits();
    t_standby();
    t_clock();
    final_report();
  end
endmodule // tb
